//--- prs_cfg.svh
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH

// ==========================================================
// timebase
`define PRS_CLK_KHZ        25000
`define PRS_DEBOUNCE_MS    50
`define PRS_EXT_DELAY_MS   1
`define PRS_RESET_DELAY_MS 20
`define PRS_CNT_W          21

// ==========================================================
// device register selects and fields
`define PRS_SEL_CTRL_A     2'h0
`define PRS_SEL_CTRL_B     2'h1
`define PRS_SEL_CHG_A      2'h2
`define PRS_SEL_STATUS     2'h3
`define PRS_BUCK_SEQ_DEF   3'h4
`define PRS_LIN_SEQ_DEF    3'h7
`define PRS_CTRL_A_DEF     8'h3c
`define PRS_A_BUCK_MSB     2
`define PRS_A_BUCK_LSB     0
`define PRS_A_LIN_MSB      5
`define PRS_A_LIN_LSB      3
`define PRS_B_MASK         0
`define PRS_B_SAVED        1
`define PRS_B_REQ          2
`define PRS_MASK_DEF       1'b1
`define PRS_C_NTC100K      0

// ==========================================================
// host controller AHB-Lite map
`define PRS_H_CTRL         8'h00
`define PRS_H_STATUS       8'h04
`define PRS_H_CMD          8'h08
`define PRS_H_RESULT       8'h0c
`define PRS_H_CMD_SEL_MSB  9
`define PRS_H_CMD_SEL_LSB  8
`define PRS_H_CMD_RD       16
`define PRS_H_RES_DONE     8

`endif

//--- prs_pkg.sv
package prs_pkg;
    typedef enum logic [2:0]
    {
        PRS_OFF      = 3'b000,
        PRS_DEBOUNCE = 3'b001,
        PRS_EXTDLY   = 3'b010,
        PRS_WAITLB   = 3'b011,
        PRS_RUN      = 3'b100,
        PRS_DEEP     = 3'b101
    } prs_state_t;

    typedef logic [1:0] prs_sel_t;
    typedef logic [7:0] prs_byte_t;
endpackage

//--- prs_link_if.sv
`timescale 1ns/1ps
interface prs_link_if;
    import prs_pkg::*;
    logic      keypressOutN;
    logic      powerOkResetOut;
    logic      buckCEnablePin;
    prs_sel_t  regSel;
    logic      regWrEn;
    logic      regRdEn;
    prs_byte_t regWdata;
    prs_byte_t regRdata;

    modport device (output keypressOutN, output powerOkResetOut, output regRdata,
                    input buckCEnablePin, input regSel, input regWrEn, input regRdEn, input regWdata);
    modport host   (input keypressOutN, input powerOkResetOut, input regRdata,
                    output buckCEnablePin, output regSel, output regWrEn, output regRdEn, output regWdata);
endinterface

//--- prs_device.sv
`timescale 1ns/1ps
`include "prs_cfg.svh"
module prs_device
    import prs_pkg::*;
#(
    parameter int DEBOUNCE_CYC = `PRS_DEBOUNCE_MS * `PRS_CLK_KHZ,
    parameter int EXT_CYC      = `PRS_EXT_DELAY_MS * `PRS_CLK_KHZ,
    parameter int RESET_CYC    = `PRS_RESET_DELAY_MS * `PRS_CLK_KHZ
)
(
    input  wire logic  clock,
    input  wire logic  rst,
    input  wire logic  ce,
    prs_link_if.device link,
    input  wire logic  buttonSenseInN,
    input  wire logic  uvloIn,
    input  wire logic  linearBGood,
    input  wire logic  buckAGood,
    input  wire logic  ntcColdIn,
    input  wire logic  ntcHotIn,
    output logic       batteryFetOn,
    output logic       extRegulatorEnable,
    output logic       linearBEnable,
    output logic       buckCEnable,
    output logic       buckAEnable,
    output logic       buckBEnable,
    output logic       linearAEnable,
    output logic       chargeSuspend,
    output logic       ntcSelect100k
);
    localparam logic [`PRS_CNT_W-1:0] DEB_C = `PRS_CNT_W'(DEBOUNCE_CYC);
    localparam logic [`PRS_CNT_W-1:0] EXT_C = `PRS_CNT_W'(EXT_CYC - 1);
    localparam logic [`PRS_CNT_W-1:0] RST_C = `PRS_CNT_W'(RESET_CYC);

    // ==========================================================
    // state
    prs_state_t             state_reg;
    prs_state_t             state_next;
    logic [`PRS_CNT_W-1:0]  pressCnt_reg;
    logic [`PRS_CNT_W-1:0]  pressCnt_next;
    logic [`PRS_CNT_W-1:0]  seqCnt_reg;
    logic [`PRS_CNT_W-1:0]  seqCnt_next;
    logic [6:0]             rails_reg;
    logic [6:0]             rails_next;
    logic                   powerOk_reg;
    logic                   keypressN_reg;
    logic                   suspend_reg;
    prs_byte_t              ctrlA_reg;
    prs_byte_t              ctrlA_next;
    logic                   mask_reg;
    logic                   mask_next;
    logic                   saved_reg;
    logic                   saved_next;
    logic                   request_reg;
    logic                   request_next;
    logic                   ntc100k_reg;
    logic                   ntc100k_next;
    prs_byte_t              rdata_reg;

    // ==========================================================
    // decode
    wire logic       pressed     = (pressCnt_reg == DEB_C);
    wire logic       extDone     = (seqCnt_reg == EXT_C);
    wire logic       rstDone     = (seqCnt_reg == RST_C);
    wire logic [2:0] buckSeq     = ctrlA_reg[`PRS_A_BUCK_MSB:`PRS_A_BUCK_LSB];
    wire logic [2:0] linSeq      = ctrlA_reg[`PRS_A_LIN_MSB:`PRS_A_LIN_LSB];
    wire logic       seqSelected = (buckSeq == `PRS_BUCK_SEQ_DEF) && (linSeq == `PRS_LIN_SEQ_DEF);
    wire logic       wrA         = link.regWrEn && (link.regSel == `PRS_SEL_CTRL_A);
    wire logic       wrB         = link.regWrEn && (link.regSel == `PRS_SEL_CTRL_B);
    wire logic       wrC         = link.regWrEn && (link.regSel == `PRS_SEL_CHG_A);
    wire logic       wakeClear   = (state_reg == PRS_DEEP) && pressed;
    wire prs_byte_t  ctrlBView   = {5'h00, request_reg, saved_reg, mask_reg};
    wire prs_byte_t  statusView  = {3'h0, keypressN_reg, powerOk_reg, state_reg};

    wire prs_byte_t  rdMux;
    assign rdMux = (link.regSel == `PRS_SEL_CTRL_A) ? ctrlA_reg :
                   (link.regSel == `PRS_SEL_CTRL_B) ? ctrlBView :
                   (link.regSel == `PRS_SEL_CHG_A)  ? {7'h00, ntc100k_reg} : statusView;

    // ==========================================================
    // registers; a host write wins over the wake-up clear
    assign ctrlA_next   = uvloIn ? `PRS_CTRL_A_DEF : (wrA ? link.regWdata : ctrlA_reg);
    assign mask_next    = uvloIn ? `PRS_MASK_DEF : (wrB ? link.regWdata[`PRS_B_MASK] : mask_reg);
    assign saved_next   = uvloIn ? 1'b0 : (wrB ? link.regWdata[`PRS_B_SAVED] : saved_reg);
    assign request_next = uvloIn ? 1'b0 :
                          wrB ? link.regWdata[`PRS_B_REQ] :
                          (wakeClear ? 1'b0 : request_reg);
    assign ntc100k_next = uvloIn ? 1'b0 : (wrC ? link.regWdata[`PRS_C_NTC100K] : ntc100k_reg);

    // ==========================================================
    // debounce counter runs in every state, including off
    assign pressCnt_next = buttonSenseInN ? '0 :
                           (pressed ? pressCnt_reg : pressCnt_reg + `PRS_CNT_W'(1));

    // ==========================================================
    // sequencer
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            PRS_OFF:
                if (!buttonSenseInN)
                    state_next = PRS_DEBOUNCE;
            PRS_DEBOUNCE:
                if (buttonSenseInN)
                    state_next = PRS_OFF;
                else if (pressed)
                    state_next = PRS_EXTDLY;
            PRS_EXTDLY:
                if (extDone)
                    state_next = seqSelected ? PRS_WAITLB : PRS_RUN;
            PRS_WAITLB:
                if (linearBGood)
                    state_next = PRS_RUN;
            PRS_RUN:
                if (request_reg)
                    state_next = PRS_DEEP;
            PRS_DEEP:
                if (pressed)
                    state_next = PRS_EXTDLY;
            default:
                state_next = PRS_OFF;
        endcase
        if (uvloIn)
            state_next = PRS_OFF;
    end

    always_comb
    begin
        seqCnt_next = '0;
        if (state_next == state_reg)
        begin
            if (state_reg == PRS_EXTDLY)
                seqCnt_next = seqCnt_reg + `PRS_CNT_W'(1);
            else if (state_reg == PRS_RUN && buckAGood)
                seqCnt_next = rstDone ? seqCnt_reg : seqCnt_reg + `PRS_CNT_W'(1);
        end
    end

    // rails: {fet, ext, linB, buckC, buckA, buckB, linA}
    wire logic onNext   = (state_next != PRS_OFF);
    wire logic seqOn    = (state_next == PRS_EXTDLY) || (state_next == PRS_WAITLB) || (state_next == PRS_RUN);
    wire logic linBOn   = (state_next == PRS_WAITLB) || (state_next == PRS_RUN);
    wire logic runNext  = (state_next == PRS_RUN);
    wire logic buckBOn  = runNext || (state_next == PRS_DEEP) || (rails_reg[1] && onNext);
    assign rails_next = {onNext,
                         seqOn,
                         linBOn,
                         linBOn && (mask_reg || link.buckCEnablePin),
                         runNext,
                         buckBOn,
                         runNext && link.buckCEnablePin};

    wire logic powerOkNext = (state_reg == PRS_RUN) && rstDone && buckAGood && !request_reg;
    wire logic keypressNext = !(pressed && onNext);

    // ==========================================================
    // flops
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_reg     <= PRS_OFF;
            pressCnt_reg  <= '0;
            seqCnt_reg    <= '0;
            rails_reg     <= '0;
            powerOk_reg   <= 1'b0;
            keypressN_reg <= 1'b1;
            suspend_reg   <= 1'b0;
            rdata_reg     <= '0;
        end
        else if (ce)
        begin
            state_reg     <= state_next;
            pressCnt_reg  <= pressCnt_next;
            seqCnt_reg    <= seqCnt_next;
            rails_reg     <= rails_next;
            powerOk_reg   <= powerOkNext;
            keypressN_reg <= keypressNext;
            suspend_reg   <= ntcColdIn || ntcHotIn;
            if (link.regRdEn)
                rdata_reg <= rdMux;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ctrlA_reg   <= `PRS_CTRL_A_DEF;
            mask_reg    <= `PRS_MASK_DEF;
            saved_reg   <= 1'b0;
            request_reg <= 1'b0;
            ntc100k_reg <= 1'b0;
        end
        else if (ce)
        begin
            ctrlA_reg   <= ctrlA_next;
            mask_reg    <= mask_next;
            saved_reg   <= saved_next;
            request_reg <= request_next;
            ntc100k_reg <= ntc100k_next;
        end
    end

    // ==========================================================
    // outputs
    assign batteryFetOn         = rails_reg[6];
    assign extRegulatorEnable   = rails_reg[5];
    assign linearBEnable        = rails_reg[4];
    assign buckCEnable          = rails_reg[3];
    assign buckAEnable          = rails_reg[2];
    assign buckBEnable          = rails_reg[1];
    assign linearAEnable        = rails_reg[0];
    assign chargeSuspend        = suspend_reg;
    assign ntcSelect100k        = ntc100k_reg;
    assign link.keypressOutN    = keypressN_reg;
    assign link.powerOkResetOut = powerOk_reg;
    assign link.regRdata        = rdata_reg;
endmodule

//--- prs_host.sv
`timescale 1ns/1ps
`include "prs_cfg.svh"
module prs_host
    import prs_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    prs_link_if.host         link,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata
);
    // ==========================================================
    // bus decode
    logic       wrPend_reg;
    logic [7:0] wrAddr_reg;
    logic       powerEn_reg;
    logic       kpPrev_reg;
    prs_sel_t   sel_reg;
    prs_byte_t  wdata_reg;
    logic       wrEn_reg;
    logic       rdEn_reg;
    logic       rdWait_reg;
    prs_byte_t  result_reg;
    logic       done_reg;
    logic [31:0] hrdata_reg;
    logic       hreadyout_reg;

    wire logic        addrPhase = hsel && htrans[1] && hready;
    wire logic        wrCtrl    = wrPend_reg && (wrAddr_reg == `PRS_H_CTRL);
    wire logic        wrCmd     = wrPend_reg && (wrAddr_reg == `PRS_H_CMD);
    wire logic        kpFall    = kpPrev_reg && !link.keypressOutN;
    wire logic        wordOk    = (hsize == 3'h2);
    wire logic [31:0] rdMux;
    assign rdMux = (haddr[7:0] == `PRS_H_CTRL)   ? {31'h0, powerEn_reg} :
                   (haddr[7:0] == `PRS_H_STATUS) ? {30'h0, link.powerOkResetOut, link.keypressOutN} :
                   (haddr[7:0] == `PRS_H_RESULT) ? {23'h0, done_reg, result_reg} : 32'h0;

    // keypress while asleep wakes the core; set wins over a software clear
    wire logic powerEnNext = kpFall ? 1'b1 : (wrCtrl ? hwdata[0] : powerEn_reg);
    // device accesses (mask clear, saved bit, deep sleep) go through the command word
    wire logic cmdRd = hwdata[`PRS_H_CMD_RD];

    // ==========================================================
    // flops
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            wrPend_reg    <= 1'b0;
            wrAddr_reg    <= 8'h00;
            hrdata_reg    <= 32'h0;
            hreadyout_reg <= 1'b0;
            powerEn_reg   <= 1'b0;
            kpPrev_reg    <= 1'b1;
        end
        else if (ce)
        begin
            hreadyout_reg <= 1'b1;
            wrPend_reg    <= addrPhase && hwrite && wordOk;
            wrAddr_reg    <= haddr[7:0];
            if (addrPhase && !hwrite)
                hrdata_reg <= rdMux;
            powerEn_reg   <= powerEnNext;
            kpPrev_reg    <= link.keypressOutN;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sel_reg    <= 2'h0;
            wdata_reg  <= 8'h00;
            wrEn_reg   <= 1'b0;
            rdEn_reg   <= 1'b0;
            rdWait_reg <= 1'b0;
            result_reg <= 8'h00;
            done_reg   <= 1'b0;
        end
        else if (ce)
        begin
            wrEn_reg   <= wrCmd && !cmdRd;
            rdEn_reg   <= wrCmd && cmdRd;
            rdWait_reg <= rdEn_reg;
            if (wrCmd)
            begin
                sel_reg   <= hwdata[`PRS_H_CMD_SEL_MSB:`PRS_H_CMD_SEL_LSB];
                wdata_reg <= hwdata[7:0];
            end
            if (rdWait_reg)
                result_reg <= link.regRdata;
            done_reg <= rdWait_reg || wrEn_reg || (done_reg && !wrCmd);
        end
    end

    // ==========================================================
    // outputs
    assign hreadyout           = hreadyout_reg;
    assign hresp               = 1'b0;
    assign hrdata              = hrdata_reg;
    assign link.buckCEnablePin = powerEn_reg;
    assign link.regSel         = sel_reg;
    assign link.regWdata       = wdata_reg;
    assign link.regWrEn        = wrEn_reg;
    assign link.regRdEn        = rdEn_reg;
endmodule

//--- prs_rail_asserts.sv
`timescale 1ns/1ps
module prs_rail_asserts
#(
    parameter int DEBOUNCE_CYC = 20,
    parameter int EXT_CYC      = 5,
    parameter int RESET_CYC    = 10
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic keypressOutN,
    input wire logic powerOkResetOut,
    input wire logic buckCEnablePin,
    input wire logic buttonSenseInN,
    input wire logic uvloIn,
    input wire logic linearBGood,
    input wire logic buckAGood,
    input wire logic ntcColdIn,
    input wire logic ntcHotIn,
    input wire logic batteryFetOn,
    input wire logic extRegulatorEnable,
    input wire logic linearBEnable,
    input wire logic buckAEnable,
    input wire logic buckBEnable,
    input wire logic linearAEnable,
    input wire logic chargeSuspend
);
    // ==========================================================
    // helper counters
    int lowCnt;
    int extCnt;
    int goodCnt;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            lowCnt  <= 0;
            extCnt  <= 0;
            goodCnt <= 0;
        end
        else
        begin
            lowCnt  <= buttonSenseInN ? 0 : lowCnt + 1;
            extCnt  <= extRegulatorEnable ? extCnt + 1 : 0;
            goodCnt <= buckAGood ? goodCnt + 1 : 0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // ==========================================================
    // sequencing
    a_fet_on_press: assert property ($fell(buttonSenseInN) && !uvloIn |-> ##[1:2] batteryFetOn)
        else $error("battery fet not on after press");
    a_debounce_len: assert property ($fell(keypressOutN) |-> lowCnt >= DEBOUNCE_CYC - 1)
        else $error("keypress before debounce time");
    a_ext_before_lin: assert property ($rose(linearBEnable) |-> extCnt >= EXT_CYC - 1)
        else $error("linear b ramp before ext delay");
    a_bucka_after_lb: assert property ($rose(buckAEnable) |-> linearBGood)
        else $error("buck a ramp before linear b good");
    a_lina_needs_pin: assert property ($rose(linearAEnable) |-> buckCEnablePin)
        else $error("linear a on without enable pin");
    a_sleep_drop: assert property ($fell(buckCEnablePin) |-> ##[1:2] !linearAEnable)
        else $error("linear a stays on in sleep");
    a_ready_delay: assert property ($rose(powerOkResetOut) |-> goodCnt >= RESET_CYC && buckAEnable)
        else $error("reset released too early");
    a_deep_rails: assert property ($fell(powerOkResetOut) && !uvloIn && !$past(uvloIn)
        |-> ##[0:2] (buckBEnable && !buckAEnable && !linearBEnable && !extRegulatorEnable))
        else $error("deep sleep rails wrong");
    a_uvlo_off: assert property (uvloIn [*2] |=> !extRegulatorEnable && !buckBEnable && !powerOkResetOut)
        else $error("rails on during undervoltage");
    a_charge_susp: assert property (chargeSuspend == ($past(ntcColdIn) || $past(ntcHotIn)))
        else $error("charge suspend wrong");
endmodule

//--- pmic_rail_sequencer_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
`define WAITFOR(c) begin for (n = 0; n < 300 && !(c); n++) @(posedge clock); if (!(c)) mismatches++; end
module pmic_rail_sequencer_tb_top;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        buttonSenseInN = 1'b1;
    logic        uvloIn = 1'b0;
    logic        linearBGood = 1'b0;
    logic        buckAGood = 1'b0;
    logic        ntcColdIn = 1'b0;
    logic        ntcHotIn = 1'b0;
    logic        hsel = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [2:0]  wsize = 3'h2;
    wire         hready;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        batteryFetOn, extRegulatorEnable, linearBEnable, buckCEnable;
    logic        buckAEnable, buckBEnable, linearAEnable, chargeSuspend, ntcSelect100k;
    int          mismatches = 0;
    int          checksDone = 0;

    assign hready = hreadyout;
    always #20 clock = ~clock;

    // rail good comparators follow enables one cycle later
    always @(posedge clock)
    begin
        linearBGood <= linearBEnable;
        buckAGood   <= buckAEnable;
    end

    prs_link_if prs_link_if_i ();

    prs_device #(.DEBOUNCE_CYC(20), .EXT_CYC(5), .RESET_CYC(10)) prs_device_i (
        .clock(clock), .rst(rst), .ce(ce), .link(prs_link_if_i.device),
        .buttonSenseInN(buttonSenseInN), .uvloIn(uvloIn), .linearBGood(linearBGood), .buckAGood(buckAGood),
        .ntcColdIn(ntcColdIn), .ntcHotIn(ntcHotIn), .batteryFetOn(batteryFetOn),
        .extRegulatorEnable(extRegulatorEnable), .linearBEnable(linearBEnable), .buckCEnable(buckCEnable),
        .buckAEnable(buckAEnable), .buckBEnable(buckBEnable), .linearAEnable(linearAEnable),
        .chargeSuspend(chargeSuspend), .ntcSelect100k(ntcSelect100k));

    prs_host prs_host_i (
        .clock(clock), .rst(rst), .ce(ce), .link(prs_link_if_i.host), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

    prs_rail_asserts #(.DEBOUNCE_CYC(20), .EXT_CYC(5), .RESET_CYC(10)) prs_rail_asserts_i (
        .clock(clock), .rst(rst), .keypressOutN(prs_link_if_i.keypressOutN),
        .powerOkResetOut(prs_link_if_i.powerOkResetOut), .buckCEnablePin(prs_link_if_i.buckCEnablePin),
        .buttonSenseInN(buttonSenseInN), .uvloIn(uvloIn), .linearBGood(linearBGood), .buckAGood(buckAGood),
        .ntcColdIn(ntcColdIn), .ntcHotIn(ntcHotIn), .batteryFetOn(batteryFetOn),
        .extRegulatorEnable(extRegulatorEnable), .linearBEnable(linearBEnable), .buckAEnable(buckAEnable),
        .buckBEnable(buckBEnable), .linearAEnable(linearAEnable), .chargeSuspend(chargeSuspend));

    // ==========================================================
    // expectations and stimulus helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic logic [31:0] exp_status(input logic kn, input logic pok);
        return {30'h0, pok, kn};
    endfunction

    function automatic logic [7:0] exp_ctrl_b(input logic req, input logic saved, input logic mask);
        return {5'h0, req, saved, mask};
    endfunction

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        hsize  <= wsize;
        do @(posedge clock); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    // device register access through the host command word
    task automatic dev_op(input logic rd, input logic [1:0] sel, input logic [7:0] d, output logic [7:0] q);
        logic [31:0] r;
        int          k;
        ahb(1'b1, 8'h08, {15'h0, rd, 6'h0, sel, d}, r);
        r = 32'h0;
        for (k = 0; k < 50 && r[8] !== 1'b1; k++)
            ahb(1'b0, 8'h0c, 32'h0, r);
        q = r[7:0];
        if (r[8] !== 1'b1)
            mismatches++;
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        #400000;
        mismatches++;
        complete_run();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        logic [31:0] w;
        logic [31:0] seed;
        logic [7:0]  q;
        int          n;
        seed = 32'd26325;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        `CHK("fet off", 1'b0, batteryFetOn)
        dev_op(1'b1, 2'h0, 8'h0, q);
        `CHK("ctrl_a", 8'h3c, q)
        dev_op(1'b1, 2'h1, 8'h0, q);
        `CHK("ctrl_b", exp_ctrl_b(0, 0, 1), q)
        ahb(1'b0, 8'h04, 32'h0, w);
        `CHK("status", exp_status(1, 0), w)
        ahb(1'b0, 8'h10, 32'h0, w);
        `CHK("unmapped", 32'h0, w)
        buttonSenseInN <= 1'b0;
        `WAITFOR(prs_link_if_i.keypressOutN === 1'b0)
        `CHK("fet on", 1'b1, batteryFetOn)
        `CHK("ext en", 1'b1, extRegulatorEnable)
        `CHK("lin b early", 1'b0, linearBEnable)
        `WAITFOR(linearBEnable === 1'b1)
        `CHK("buck c", 1'b1, buckCEnable)
        `WAITFOR(buckAEnable === 1'b1)
        `CHK("buck b", 1'b1, buckBEnable)
        buttonSenseInN <= 1'b1;
        `WAITFOR(prs_link_if_i.powerOkResetOut === 1'b1)
        `CHK("lin a", 1'b1, linearAEnable)
        ahb(1'b0, 8'h04, 32'h0, w);
        `CHK("status run", exp_status(1, 1), w)
        dev_op(1'b0, 2'h1, exp_ctrl_b(0, 0, 0), q);
        ahb(1'b1, 8'h00, 32'h0, w);
        repeat (4) @(posedge clock);
        `CHK("sleep buck c", 1'b0, buckCEnable)
        `CHK("sleep lin a", 1'b0, linearAEnable)
        `CHK("sleep buck a", 1'b1, buckAEnable)
        buttonSenseInN <= 1'b0;
        `WAITFOR(linearAEnable === 1'b1)
        `CHK("wake buck c", 1'b1, buckCEnable)
        buttonSenseInN <= 1'b1;
        `WAITFOR(prs_link_if_i.keypressOutN === 1'b1)
        dev_op(1'b0, 2'h1, exp_ctrl_b(0, 1, 0), q);
        dev_op(1'b0, 2'h1, exp_ctrl_b(1, 1, 0), q);
        `WAITFOR(prs_link_if_i.powerOkResetOut === 1'b0)
        repeat (3) @(posedge clock);
        `CHK("deep buck b", 1'b1, buckBEnable)
        `CHK("deep buck a", 1'b0, buckAEnable)
        `CHK("deep lin a", 1'b0, linearAEnable)
        buttonSenseInN <= 1'b0;
        `WAITFOR(prs_link_if_i.powerOkResetOut === 1'b1)
        buttonSenseInN <= 1'b1;
        `CHK("deep wake buck a", 1'b1, buckAEnable)
        dev_op(1'b1, 2'h1, 8'h0, q);
        `CHK("req cleared", exp_ctrl_b(0, 1, 0), q)
        dev_op(1'b0, 2'h1, exp_ctrl_b(0, 0, 0), q);
        dev_op(1'b1, 2'h1, 8'h0, q);
        `CHK("saved cleared", exp_ctrl_b(0, 0, 0), q)
        dev_op(1'b1, 2'h3, 8'h0, q);
        `CHK("dev status", 8'h1c, q)
        `CHK("hresp", 1'b0, hresp)
        // frozen host and non-word write must both leave the pin high
        ce <= 1'b0;
        ahb(1'b1, 8'h00, 32'h0, w);
        ce <= 1'b1;
        wsize = 3'h0;
        ahb(1'b1, 8'h00, 32'h0, w);
        wsize = 3'h2;
        repeat (2) @(posedge clock);
        `CHK("held pin lin a", 1'b1, linearAEnable)
        `CHK("held pin buck c", 1'b1, buckCEnable)
        `CHK("ntc default", 1'b0, ntcSelect100k)
        repeat (8)
        begin
            seed = xs(seed);
            dev_op(1'b0, 2'h2, seed[7:0], q);
            `CHK("ntc sel", seed[0], ntcSelect100k)
            ntcColdIn <= seed[8];
            ntcHotIn  <= seed[9];
            repeat (2) @(posedge clock);
            `CHK("suspend", seed[8] | seed[9], chargeSuspend)
        end
        dev_op(1'b0, 2'h1, exp_ctrl_b(0, 1, 0), q);
        uvloIn <= 1'b1;
        repeat (3) @(posedge clock);
        uvloIn <= 1'b0;
        @(posedge clock);
        `CHK("uvlo ext", 1'b0, extRegulatorEnable)
        `CHK("uvlo pok", 1'b0, prs_link_if_i.powerOkResetOut)
        `CHK("uvlo ntc", 1'b0, ntcSelect100k)
        dev_op(1'b1, 2'h1, 8'h0, q);
        `CHK("uvlo ctrl_b", exp_ctrl_b(0, 0, 1), q)
        seed = xs(seed);
        dev_op(1'b0, 2'h0, seed[7:0], q);
        dev_op(1'b1, 2'h0, 8'h0, q);
        `CHK("ctrl_a wr", seed[7:0], q)
        complete_run();
    end
endmodule
